/* File: include/oarp_defs.svh */
/*
  Constants of the security-area and read-parameter command block:
  opcodes, address field positions, reset values and timing figures.
  Assumes inclusion by bare name; uses nothing from oarp_pkg.
*/
`ifndef OARP_DEFS_SVH
`define OARP_DEFS_SVH

// ----------------------------------------------------------------
// opcodes
// ----------------------------------------------------------------
`define OARP_OP_SEC_ERASE     8'h44
`define OARP_OP_SEC_PROG      8'h42
`define OARP_OP_SEC_READ      8'h48
`define OARP_OP_SET_PARAM     8'hc0
`define OARP_OP_WRAP_READ     8'h0c
`define OARP_OP_DTR_WRAP_READ 8'h0e

// ----------------------------------------------------------------
// address and field layout
// ----------------------------------------------------------------
`define OARP_AREA_SEL_MSB     15
`define OARP_AREA_SEL_LSB     12
`define OARP_AREA_ZERO_MSB    11
`define OARP_AREA_ZERO_LSB    8
`define OARP_AREA_BYTES       256
`define OARP_AREA_COUNT       3
`define OARP_ERASED_BYTE      8'hff
`define OARP_ADDR3_BITS       6'h18
`define OARP_ADDR4_BITS       6'h20
`define OARP_BYTE_BITS        6'h08
`define OARP_SERIAL_DUMMY     6'h08
`define OARP_PARAM_DUMMY_MSB  5
`define OARP_PARAM_DUMMY_LSB  4
`define OARP_PARAM_WRAP_MSB   1
`define OARP_PARAM_WRAP_LSB   0
`define OARP_WRAP_MIN_BYTES   32'h8

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define OARP_DUMMY_RST        2'h0
`define OARP_WRAP_RST         2'h0

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define OARP_REF_CLK_NS       20
`define OARP_SEC_ERASE_US     50
`define OARP_SEC_PROG_US      10

`endif

/* File: include/oarp_pkg.sv */
/*
  Types of the security-area and read-parameter command block.
  Assumes nothing of its surroundings.
*/
package oarp_pkg;

  // ----------------------------------------------------------------
  // link phase, gray along opcode-address-dummy-data
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PH_OPC   = 3'h0,
    PH_ADDR  = 3'h1,
    PH_DUMMY = 3'h3,
    PH_DATA  = 3'h2,
    PH_IGN   = 3'h6
  } oarp_phase_t;

  // ----------------------------------------------------------------
  // decoded command
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CMD_NONE  = 3'h0,
    CMD_ERASE = 3'h1,
    CMD_PROG  = 3'h2,
    CMD_READ  = 3'h3,
    CMD_PARAM = 3'h4,
    CMD_WRAP  = 3'h5
  } oarp_cmd_t;

  // ----------------------------------------------------------------
  // self-timed cycle engine
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CORE_IDLE = 2'h0,
    CORE_WALK = 2'h1,
    CORE_WAIT = 2'h3
  } oarp_core_st_t;

endpackage

/* File: verilog/oarp_core.sv */
/*
  Command block of a serial flash: three security areas (erase, program,
  read), the quad-mode read-parameter setting and the wrapped burst reads.
  Assumes sclk_i toggles only while cs_n_i is low, mode inputs change only
  between frames, and array_rdata_i answers array_addr_o combinationally.
*/
`timescale 1ns/1ps
`default_nettype none
`include "oarp_defs.svh"

module oarp_core
  import oarp_pkg::*;
#(
  parameter int unsigned ERASE_CYC = ((`OARP_SEC_ERASE_US * 1000) + `OARP_REF_CLK_NS - 1) / `OARP_REF_CLK_NS,
  parameter int unsigned PROG_CYC  = ((`OARP_SEC_PROG_US * 1000) + `OARP_REF_CLK_NS - 1) / `OARP_REF_CLK_NS
) (
  // core clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        resetn_i,
  // link pins
  input  wire logic        sclk_i,
  input  wire logic        cs_n_i,
  input  wire logic [3:0]  io_i,
  output logic      [3:0]  io_o,
  output logic      [3:0]  io_oe_o,
  // device mode and control
  input  wire logic        quad_command_mode_i,
  input  wire logic        four_byte_mode_i,
  input  wire logic [2:0]  security_area_lock_bits_i,
  input  wire logic        wel_set_i,
  input  wire logic        wel_clear_i,
  input  wire logic        soft_reset_i,
  input  wire logic        serial_wrap_load_i,
  input  wire logic [1:0]  serial_wrap_field_i,
  // main array read port
  input  wire logic [7:0]  array_rdata_i,
  output logic      [31:0] array_addr_o,
  // status
  output logic             busy_o,
  output logic             write_enable_latch_o,
  output logic      [1:0]  dummy_cycle_field_o,
  output logic      [1:0]  wrap_length_field_o
);

  // ----------------------------------------------------------------
  // storage and state
  // ----------------------------------------------------------------
  logic [7:0]                  sec_mem [0:(`OARP_AREA_COUNT * `OARP_AREA_BYTES) - 1];
  logic [7:0]                  pbuf    [0:`OARP_AREA_BYTES - 1];
  logic [`OARP_AREA_BYTES-1:0] pmask_r;
  oarp_phase_t                 ph_r;
  oarp_cmd_t                   cmd_r;
  oarp_cmd_t                   cmd_dec;
  oarp_phase_t                 ph_dec;
  oarp_core_st_t               st_r;
  logic [5:0]                  bcnt_r;
  logic [5:0]                  bcnt_nxt;
  logic [5:0]                  alen;
  logic [5:0]                  dummy_len;
  logic [31:0]                 sh_r;
  logic [31:0]                 sh_nxt;
  logic [31:0]                 addr_r;
  logic [31:0]                 addr_in;
  logic [31:0]                 addr_wrap;
  logic [31:0]                 wrap_mask;
  logic [3:0]                  area_sel;
  logic [1:0]                  area_dec;
  logic [1:0]                  area_r;
  logic [7:0]                  rd_byte;
  logic [7:0]                  param_r;
  logic                        erase_ok_r;
  logic                        prog_any_r;
  logic                        param_ok_r;
  logic                        quad;
  logic                        cs_s1_r;
  logic                        cs_s2_r;
  logic                        cs_s3_r;
  logic                        cs_rise;
  logic                        go_erase;
  logic                        go_prog;
  logic                        go_param;
  logic                        done_p;
  logic                        op_erase_r;
  logic [1:0]                  sel_r;
  logic [7:0]                  idx_r;
  logic [31:0]                 cnt_r;
  logic                        busy_r;
  logic                        wel_r;
  logic [1:0]                  dummy_field_r;
  logic [1:0]                  wrap_field_r;

  assign quad = quad_command_mode_i;

  // ----------------------------------------------------------------
  // link decode
  // ----------------------------------------------------------------
  always_comb begin
    sh_nxt    = quad ? {sh_r[27:0], io_i} : {sh_r[30:0], io_i[0]};
    bcnt_nxt  = bcnt_r + (quad ? 6'h4 : 6'h1);
    alen      = four_byte_mode_i ? `OARP_ADDR4_BITS : `OARP_ADDR3_BITS;
    dummy_len = quad ? ({3'h0, dummy_field_r, 1'b0} + 6'h2) : `OARP_SERIAL_DUMMY;
    addr_in   = four_byte_mode_i ? sh_nxt : {8'h00, sh_nxt[23:0]};
    area_sel  = addr_in[`OARP_AREA_SEL_MSB:`OARP_AREA_SEL_LSB];
    area_dec  = 2'h0;
    if (addr_in[31:16] == 16'h0 && addr_in[`OARP_AREA_ZERO_MSB:`OARP_AREA_ZERO_LSB] == 4'h0 &&
        area_sel != 4'h0 && area_sel < 4'h4) begin
      area_dec = area_sel[1:0];
    end
    wrap_mask = (`OARP_WRAP_MIN_BYTES << wrap_field_r) - 32'h1;
    addr_wrap = (addr_r & ~wrap_mask) | ((addr_r + 32'h1) & wrap_mask);
    rd_byte   = array_rdata_i;
    if (cmd_r == CMD_READ) begin
      rd_byte = (area_r != 2'h0) ? sec_mem[{2'(area_r - 2'h1), addr_r[7:0]}] : `OARP_ERASED_BYTE;
    end
    cmd_dec = CMD_NONE;
    ph_dec  = PH_IGN;
    if (!quad && sh_nxt[7:0] == `OARP_OP_SEC_ERASE) begin
      cmd_dec = CMD_ERASE;
      ph_dec  = PH_ADDR;
    end else if (!quad && sh_nxt[7:0] == `OARP_OP_SEC_PROG) begin
      cmd_dec = CMD_PROG;
      ph_dec  = PH_ADDR;
    end else if (!quad && sh_nxt[7:0] == `OARP_OP_SEC_READ) begin
      cmd_dec = CMD_READ;
      ph_dec  = PH_ADDR;
    end else if (quad && sh_nxt[7:0] == `OARP_OP_SET_PARAM) begin
      cmd_dec = CMD_PARAM;
      ph_dec  = PH_DATA;
    end else if (quad && (sh_nxt[7:0] == `OARP_OP_WRAP_READ || sh_nxt[7:0] == `OARP_OP_DTR_WRAP_READ)) begin
      cmd_dec = CMD_WRAP;
      ph_dec  = PH_ADDR;
    end
  end

  // ----------------------------------------------------------------
  // link sequencer, rising edge, cleared while deselected
  // ----------------------------------------------------------------
  always_ff @(posedge sclk_i or posedge cs_n_i or negedge resetn_i) begin
    if (!resetn_i || cs_n_i) begin
      ph_r   <= PH_OPC;
      cmd_r  <= CMD_NONE;
      bcnt_r <= 6'h0;
      sh_r   <= 32'h0;
    end else begin
      unique case (ph_r)
        PH_OPC: begin
          sh_r <= sh_nxt;
          if (bcnt_nxt == `OARP_BYTE_BITS) begin
            bcnt_r <= 6'h0;
            cmd_r  <= cmd_dec;
            ph_r   <= ph_dec;
          end else begin
            bcnt_r <= bcnt_nxt;
          end
        end
        PH_ADDR: begin
          sh_r <= sh_nxt;
          if (bcnt_nxt == alen) begin
            bcnt_r <= 6'h0;
            ph_r   <= (cmd_r == CMD_ERASE || cmd_r == CMD_PROG) ? PH_DATA : PH_DUMMY;
          end else begin
            bcnt_r <= bcnt_nxt;
          end
        end
        PH_DUMMY: begin
          if (bcnt_r + 6'h1 == dummy_len) begin
            bcnt_r <= 6'h0;
            ph_r   <= PH_DATA;
          end else begin
            bcnt_r <= bcnt_r + 6'h1;
          end
        end
        PH_DATA: begin
          sh_r   <= sh_nxt;
          bcnt_r <= (bcnt_nxt == `OARP_BYTE_BITS) ? 6'h0 : bcnt_nxt;
        end
        PH_IGN: begin
          bcnt_r <= bcnt_r;
        end
        default: begin
          ph_r <= PH_IGN;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // frame results, kept past chip select for the core
  // ----------------------------------------------------------------
  always_ff @(posedge sclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      erase_ok_r <= 1'b0;
      prog_any_r <= 1'b0;
      param_ok_r <= 1'b0;
      pmask_r    <= '0;
      area_r     <= 2'h0;
      addr_r     <= 32'h0;
      param_r    <= 8'h0;
    end else begin
      if (ph_r == PH_OPC && bcnt_r == 6'h0) begin
        erase_ok_r <= 1'b0;
        prog_any_r <= 1'b0;
        param_ok_r <= 1'b0;
        pmask_r    <= '0;
        area_r     <= 2'h0;
      end
      if (ph_r == PH_ADDR && bcnt_nxt == alen) begin
        addr_r     <= addr_in;
        area_r     <= area_dec;
        erase_ok_r <= (cmd_r == CMD_ERASE);
      end
      if (ph_r == PH_DATA) begin
        if (cmd_r == CMD_ERASE) begin
          erase_ok_r <= 1'b0;
        end
        if (bcnt_nxt == `OARP_BYTE_BITS) begin
          if (cmd_r == CMD_PROG) begin
            pmask_r[addr_r[7:0]] <= 1'b1;
            prog_any_r           <= 1'b1;
            addr_r[7:0]          <= addr_r[7:0] + 8'h1;
          end else if (cmd_r == CMD_READ) begin
            addr_r[7:0] <= addr_r[7:0] + 8'h1;
          end else if (cmd_r == CMD_WRAP) begin
            addr_r <= addr_wrap;
          end else if (cmd_r == CMD_PARAM) begin
            param_r    <= sh_nxt[7:0];
            param_ok_r <= 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge sclk_i) begin
    if (ph_r == PH_DATA && cmd_r == CMD_PROG && bcnt_nxt == `OARP_BYTE_BITS) begin
      pbuf[addr_r[7:0]] <= sh_nxt[7:0];
    end
  end

  assign array_addr_o = addr_r;

  // ----------------------------------------------------------------
  // read data out, falling edge
  // ----------------------------------------------------------------
  always_ff @(negedge sclk_i or posedge cs_n_i or negedge resetn_i) begin
    if (!resetn_i || cs_n_i) begin
      io_o    <= 4'h0;
      io_oe_o <= 4'h0;
    end else if (ph_r == PH_DATA && cmd_r == CMD_READ) begin
      io_oe_o <= 4'h2;
      io_o    <= {2'h0, rd_byte[~bcnt_r[2:0]], 1'b0};
    end else if (ph_r == PH_DATA && cmd_r == CMD_WRAP) begin
      io_oe_o <= 4'hf;
      io_o    <= bcnt_r[2] ? rd_byte[3:0] : rd_byte[7:4];
    end else begin
      io_o    <= 4'h0;
      io_oe_o <= 4'h0;
    end
  end

  // ----------------------------------------------------------------
  // frame end crossing into the core
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cs_s1_r <= 1'b1;
      cs_s2_r <= 1'b1;
      cs_s3_r <= 1'b1;
    end else begin
      cs_s1_r <= cs_n_i;
      cs_s2_r <= cs_s1_r;
      cs_s3_r <= cs_s2_r;
    end
  end

  assign cs_rise  = cs_s2_r & ~cs_s3_r;
  assign go_erase = cs_rise && st_r == CORE_IDLE && wel_r && erase_ok_r && area_r != 2'h0 &&
                    !security_area_lock_bits_i[2'(area_r - 2'h1)];
  assign go_prog  = cs_rise && st_r == CORE_IDLE && wel_r && prog_any_r && area_r != 2'h0 &&
                    !security_area_lock_bits_i[2'(area_r - 2'h1)];
  assign go_param = cs_rise && param_ok_r && quad;
  assign done_p   = (st_r == CORE_WAIT) && (cnt_r >= (op_erase_r ? ERASE_CYC : PROG_CYC) - 1);

  // ----------------------------------------------------------------
  // self-timed erase and program engine
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_r       <= CORE_IDLE;
      idx_r      <= 8'h0;
      cnt_r      <= 32'h0;
      sel_r      <= 2'h0;
      op_erase_r <= 1'b0;
      busy_r     <= 1'b0;
    end else begin
      unique case (st_r)
        CORE_IDLE: begin
          if (go_erase || go_prog) begin
            st_r       <= CORE_WALK;
            idx_r      <= 8'h0;
            cnt_r      <= 32'h0;
            sel_r      <= 2'(area_r - 2'h1);
            op_erase_r <= go_erase;
            busy_r     <= 1'b1;
          end
        end
        CORE_WALK: begin
          cnt_r <= cnt_r + 32'h1;
          idx_r <= idx_r + 8'h1;
          if (idx_r == 8'hff) begin
            st_r <= CORE_WAIT;
          end
        end
        CORE_WAIT: begin
          cnt_r <= cnt_r + 32'h1;
          if (done_p) begin
            st_r   <= CORE_IDLE;
            busy_r <= 1'b0;
          end
        end
        default: begin
          st_r   <= CORE_IDLE;
          busy_r <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (st_r == CORE_WALK) begin
      if (op_erase_r) begin
        sec_mem[{sel_r, idx_r}] <= `OARP_ERASED_BYTE;
      end else if (pmask_r[idx_r]) begin
        sec_mem[{sel_r, idx_r}] <= sec_mem[{sel_r, idx_r}] & pbuf[idx_r];
      end
    end
  end

  // ----------------------------------------------------------------
  // write enable latch and read parameters
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wel_r <= 1'b0;
    end else if (wel_set_i) begin
      wel_r <= 1'b1;
    end else if (done_p || wel_clear_i || soft_reset_i) begin
      wel_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      dummy_field_r <= `OARP_DUMMY_RST;
      wrap_field_r  <= `OARP_WRAP_RST;
    end else if (soft_reset_i) begin
      dummy_field_r <= `OARP_DUMMY_RST;
      wrap_field_r  <= `OARP_WRAP_RST;
    end else if (go_param) begin
      dummy_field_r <= param_r[`OARP_PARAM_DUMMY_MSB:`OARP_PARAM_DUMMY_LSB];
      wrap_field_r  <= param_r[`OARP_PARAM_WRAP_MSB:`OARP_PARAM_WRAP_LSB];
    end else if (serial_wrap_load_i && !quad) begin
      wrap_field_r <= serial_wrap_field_i;
    end
  end

  assign busy_o               = busy_r;
  assign write_enable_latch_o = wel_r;
  assign dummy_cycle_field_o  = dummy_field_r;
  assign wrap_length_field_o  = wrap_field_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_cycle_start;
    $rose(busy_r);
  endsequence

  wel_gate_a: assert property (
    @(posedge ref_clk_i) disable iff (!resetn_i) s_cycle_start |-> $past(wel_r))
    else $error("cycle started without write enable latch");

  busy_hold_a: assert property (
    @(posedge ref_clk_i) disable iff (!resetn_i) s_cycle_start |-> busy_r [*8])
    else $error("busy dropped early");

  erase_fill_a: assert property (
    @(posedge ref_clk_i) disable iff (!resetn_i)
    (st_r == CORE_WALK && op_erase_r && idx_r == 8'hff) |=> sec_mem[{sel_r, 8'hff}] == `OARP_ERASED_BYTE)
    else $error("erased area not ff");

  wel_done_a: assert property (
    @(posedge ref_clk_i) disable iff (!resetn_i) (done_p && !wel_set_i) |=> !wel_r && !busy_r)
    else $error("latch kept after cycle");

  lock_block_a: assert property (
    @(posedge ref_clk_i) disable iff (!resetn_i)
    (cs_rise && !busy_r && area_r != 2'h0 && security_area_lock_bits_i[2'(area_r - 2'h1)]) |=> !busy_r)
    else $error("locked area accepted a cycle");

  param_reset_a: assert property (
    @(posedge ref_clk_i) disable iff (!resetn_i)
    soft_reset_i |=> (dummy_field_r == `OARP_DUMMY_RST && wrap_field_r == `OARP_WRAP_RST))
    else $error("defaults not restored");

  param_quad_a: assert property (
    @(posedge ref_clk_i) disable iff (!resetn_i)
    $changed(dummy_field_r) |-> ($past(go_param) || $past(soft_reset_i)) && ($past(quad) || $past(soft_reset_i)))
    else $error("dummy count changed outside quad parameter command");

  sec_wrap_a: assert property (
    @(posedge sclk_i) disable iff (cs_n_i || !resetn_i)
    (ph_r == PH_DATA && cmd_r == CMD_READ && addr_r[7:0] == 8'hff && bcnt_nxt == `OARP_BYTE_BITS)
    |=> addr_r[7:0] == 8'h00 && $stable(area_r))
    else $error("security read did not wrap");

  burst_wrap_a: assert property (
    @(posedge sclk_i) disable iff (cs_n_i || !resetn_i)
    (ph_r == PH_DATA && cmd_r == CMD_WRAP && bcnt_nxt == `OARP_BYTE_BITS)
    |=> (addr_r & ~wrap_mask) == ($past(addr_r) & ~wrap_mask))
    else $error("burst left its wrap window");

  erase_bound_a: assert property (
    @(posedge sclk_i) disable iff (cs_n_i || !resetn_i)
    (ph_r == PH_DATA && cmd_r == CMD_ERASE) |=> !erase_ok_r)
    else $error("erase kept after extra clocks");

endmodule
`default_nettype wire

/* File: verification/oarp_host_model.sv */
/*
  Host link model: drives sclk, chip select and io, samples answers.
  Assumes the bench resolves each pin from the device's enables alone.
*/
`timescale 1ns/1ps
`default_nettype none
module oarp_host_model (
  output logic            sclk_o,
  output logic            cs_n_o,
  output logic      [3:0] io_o,
  input  wire logic [3:0] pin_i
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    io_o   = 4'h0;
  end
  // one link clock; io only changes after the falling edge
  task automatic tick();
    #62.5 sclk_o = 1'b1;
    #62.5 sclk_o = 1'b0;
  endtask
  task automatic put(input int n, input logic [63:0] v, input bit q);
    cs_n_o = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      io_o = q ? v[4*i+:4] : {3'h0, v[i]};
      tick();
    end
  endtask
  // released lines show the inverse of the last value
  task automatic idle(input int n);
    for (int i = 0; i < n; i++) begin
      io_o = ~io_o;
      tick();
    end
  endtask
  task automatic get(input bit q, output logic [7:0] b);
    b = 8'h00;
    io_o = ~io_o;
    for (int i = 0; i < (q ? 2 : 8); i++) begin
      #62.5 sclk_o = 1'b1;
      b = q ? {b[3:0], pin_i} : {b[6:0], pin_i[1]};
      #62.5 sclk_o = 1'b0;
    end
  endtask
  task automatic stop();
    #62.5 cs_n_o = 1'b1;
    io_o = ~io_o;
    #200;
  endtask
endmodule
`default_nettype wire

/* File: verification/tb.sv */
/*
  Bench for oarp_core: host model on the link, array model per window.
  Assumes the design carries its own assertions.
*/
`timescale 1ns/1ps
`default_nettype none
`include "oarp_defs.svh"
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin bad_count++; $display("ERROR %s exp %h got %h", nm, e, s); end end
module tb;
  logic        ref_clk_i, resetn_i, quad, sclk, csn, busy, write_enable_latch, fourb;
  logic [3:0]  ctl;
  logic [2:0]  lock;
  logic [3:0]  h_io, d_io, d_oe, pin;
  logic [31:0] addr, a, e;
  logic [1:0]  dfld, wfld, swf;
  logic [7:0]  b, p, mem [256];
  int          bad_count, n_tests, n, seed = 32'h61462784;
  assign pin = (d_oe & d_io) | (~d_oe & h_io);
  oarp_host_model h (.sclk_o(sclk), .cs_n_o(csn), .io_o(h_io), .pin_i(pin));
  oarp_core #(.ERASE_CYC(300), .PROG_CYC(300)) oarp_core_inst (
    .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .sclk_i(sclk), .cs_n_i(csn),
    .io_i(pin), .io_o(d_io), .io_oe_o(d_oe), .quad_command_mode_i(quad),
    .four_byte_mode_i(fourb), .security_area_lock_bits_i(lock), .wel_set_i(ctl[0]),
    .wel_clear_i(ctl[1]), .soft_reset_i(ctl[2]), .serial_wrap_load_i(ctl[3]),
    .serial_wrap_field_i(swf), .array_rdata_i(addr[7:0] ^ addr[15:8]), .array_addr_o(addr),
    .busy_o(busy), .write_enable_latch_o(write_enable_latch), .dummy_cycle_field_o(dfld), .wrap_length_field_o(wfld));
  initial begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end
  task automatic pul(input logic [3:0] m);
    @(posedge ref_clk_i) #2 ctl = m;
    @(posedge ref_clk_i) #2 ctl = 4'h0;
  endtask
  task automatic setin(input logic q, input logic [2:0] l, input logic f);
    @(posedge ref_clk_i) #2 quad = q;
    lock = l;
    fourb = f;
  endtask
  task automatic erase(input logic [23:0] ea, input int x);
    h.put(8, `OARP_OP_SEC_ERASE, 0);
    h.put(24 + x, {40'h0, ea} << x, 0);
    h.stop();
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wbusy();
    int i;
    for (i = 0; i < 400 && busy !== 1'b0; i++) @(posedge ref_clk_i);
    if (i == 400) begin
      bad_count++;
      close_out();
    end
  endtask
  initial begin
    ctl = 4'h0; lock = 3'h0; quad = 1'b0; fourb = 1'b0; swf = 2'h0; resetn_i = 1'b0;
    repeat (2) @(posedge ref_clk_i);
    #2 resetn_i = 1'b1;
    repeat (3) @(posedge ref_clk_i);
    `CHK("dummy", 2'h0, dfld)
    `CHK("wrap", 2'h0, wfld)
    h.put(8, `OARP_OP_SET_PARAM, 0);
    h.put(8, 8'h33, 0);
    h.stop();
    `CHK("dummy", 2'h0, dfld)
    `CHK("wrap", 2'h0, wfld)
    pul(4'h1);
    `CHK("wel", 1'b1, write_enable_latch)
    pul(4'h2);
    `CHK("wel", 1'b0, write_enable_latch)
    erase(24'h001000, 0);
    `CHK("busy", 1'b0, busy)
    setin(1'b0, 3'h2, 1'b0);
    pul(4'h1);
    erase(24'h002000, 0);
    `CHK("busy", 1'b0, busy)
    erase(24'h003000, 2);
    `CHK("busy", 1'b0, busy)
    erase(24'h004000, 0);
    `CHK("busy", 1'b0, busy)
    erase(24'h0010aa, 0);
    `CHK("busy", 1'b1, busy)
    wbusy();
    `CHK("wel", 1'b0, write_enable_latch)
    for (int i = 0; i < 256; i++) mem[i] = `OARP_ERASED_BYTE;
    $display("test erase done");
    pul(4'h1);
    h.put(8, `OARP_OP_SEC_PROG, 0);
    h.put(24, 24'h0010fe, 0);
    for (int i = 0; i < 3; i++) begin
      b = $random(seed);
      mem[(254 + i) % 256] &= b;
      h.put(8, b, 0);
    end
    h.stop();
    wbusy();
    `CHK("wel", 1'b0, write_enable_latch)
    h.put(8, `OARP_OP_SEC_READ, 0);
    h.put(24, 24'h0010fd, 0);
    h.put(8, 0, 0);
    for (int i = 0; i < 5; i++) begin
      h.get(1'b0, b);
      `CHK("area byte", mem[(253 + i) % 256], b)
    end
    h.stop();
    setin(1'b0, 3'h2, 1'b1);
    h.put(8, `OARP_OP_SEC_READ, 0);
    h.put(32, 32'h000010fe, 0);
    h.put(8, 0, 0);
    for (int i = 0; i < 2; i++) begin
      h.get(1'b0, b);
      `CHK("area byte 4b", mem[254 + i], b)
    end
    h.stop();
    setin(1'b0, 3'h2, 1'b0);
    swf = 2'h2;
    pul(4'h8);
    `CHK("wrap", 2'h2, wfld)
    $display("test program read done");
    setin(1'b1, 3'h0, 1'b0);
    `CHK("wrap", 2'h2, wfld)
    swf = 2'h1;
    pul(4'h8);
    `CHK("wrap", 2'h2, wfld)
    for (int k = 0; k < 4; k++) begin
      p = $random(seed);
      p[5:4] = k[1:0];
      h.put(2, `OARP_OP_SET_PARAM, 1);
      h.put(2, p, 1);
      h.stop();
      `CHK("dummy", k[1:0], dfld)
      `CHK("wrap", p[1:0], wfld)
      a = $random(seed) & 32'h00fffffc;
      n = 8 << p[1:0];
      h.put(2, k[0] ? `OARP_OP_DTR_WRAP_READ : `OARP_OP_WRAP_READ, 1);
      h.put(6, a, 1);
      h.idle(2 * (k + 1));
      for (int i = 0; i < n + 4; i++) begin
        e = (a & ~(n - 1)) | ((a + i) & (n - 1));
        h.get(1'b1, b);
        `CHK("wrap byte", e[7:0] ^ e[15:8], b)
      end
      h.stop();
    end
    pul(4'h1);
    h.put(2, `OARP_OP_SEC_ERASE, 1);
    h.put(6, 24'h001000, 1);
    h.stop();
    `CHK("busy", 1'b0, busy)
    pul(4'h4);
    `CHK("wel", 1'b0, write_enable_latch)
    `CHK("dummy", 2'h0, dfld)
    `CHK("wrap", 2'h0, wfld)
    $display("test quad done");
    close_out();
  end
endmodule
`default_nettype wire
